// File: csfp_pkg.sv
// Shared constants and carrier types for the codec serial frame port.
package csfp_pkg;

  localparam int WORD_BITS = 16;
  localparam int CNT_W = 8;
  localparam int BIT_W = 5;

  // Master frame layout in shift clocks: primary slot, optional secondary slot, frame length 256.
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] WORD_END = 8'h10;
  localparam logic [CNT_W-1:0] SEC_START = 8'h80;
  localparam logic [CNT_W-1:0] SEC_END = 8'h90;

  localparam logic [BIT_W-1:0] BIT_ZERO = 5'h00;
  localparam logic [BIT_W-1:0] BIT_ONE = 5'h01;
  localparam logic [BIT_W-1:0] BIT_LAST = 5'h0F;

  localparam logic [WORD_BITS-1:0] WORD_RST = 16'h0000;
  localparam logic [CNT_W-1:0] DELAY_RST = 8'h00;
  localparam logic FS_IDLE = 1'b1;

  typedef struct packed {
    logic [WORD_BITS-1:0] data;
    logic phone;
    logic [CNT_W-1:0] fsd_delay;
  } csfp_tx_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] data;
    logic secondary;
  } csfp_rx_t;

  localparam csfp_tx_t TX_RST = '{data: WORD_RST, phone: 1'b0, fsd_delay: DELAY_RST};
  localparam csfp_rx_t RX_RST = '{data: WORD_RST, secondary: 1'b0};

endpackage : csfp_pkg

// File: csfp_frame_port.sv
// Serial frame port of the codec: framing, shifting and the clock crossings around them.
// Function
// - Capture serial input on falling shift clock edge while frame sync is low.
// - Serial input is ignored whenever frame sync is inactive.
// - Launch serial output bits on rising shift clock edge while frame sync low.
// - Serial output is high impedance whenever frame sync is inactive.
// - A master drives serial output only in its own time slot.
// - A master keeps serial output released during slave frame syncs that fall outside its own slots.
// - Secondary request high adds a secondary frame half a frame after the primary.
// - Secondary request is latched at frame sync rising edge ending the primary.
// - In phone mode the flag pin shows the programmed control value.
// - Master select high makes the frame sync pin a driven output.
// - Master select low makes the frame sync pin an input.
// - A slave starts transferring when its frame sync input goes low.
// - The master generates frame sync timing for itself and the chain.
// - Master frame sync is low during each transfer and high otherwise.
// - The delayed frame sync output feeds a slave frame sync input.
// - Delayed frame sync has master duration for delays up to 240, delayed by programmed shift clocks.
// - Master select high means master, low means slave.
// - Phone mode secondary frames route alternate data onto serial output.
// - Power-down low stops the interface and clears counters and the link-side delay and phone settings, restored on wake only if tx_req_r is high.
`timescale 1ns/100ps

module csfp_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk) begin
    s1_r <= d;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // A change is taken only once the second and third stage agree.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r <= '0;
    end else if (s2_r == s3_r) begin
      q_r <= s3_r;
    end
  end

  assign q = q_r;

endmodule : csfp_sync3

module csfp_frame_port (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic power_down_n,
  input wire logic master_sel,
  input wire logic frame_sync_n_i,
  output logic frame_sync_n_o,
  output logic frame_sync_n_oe,
  output logic delayed_frame_sync_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic secondary_request,
  input wire logic alternate_data_in,
  output logic flag,
  input wire logic phone_mode,
  input wire logic ctrl2_flag,
  input wire logic [csfp_pkg::CNT_W-1:0] fsd_delay,
  input wire logic [csfp_pkg::WORD_BITS-1:0] tx_data,
  input wire logic tx_load,
  output logic tx_ready,
  output logic [csfp_pkg::WORD_BITS-1:0] rx_data,
  output logic rx_secondary,
  output logic rx_valid
);

  // System domain state.
  logic pd_q;
  logic run_r;
  logic tx_req_r;
  csfp_pkg::csfp_tx_t tx_hold_r;
  logic ack_q;
  logic rxt_q;
  logic rxt_seen_r;
  logic [csfp_pkg::WORD_BITS-1:0] rx_data_r;
  logic rx_sec_r;
  logic rx_valid_r;
  logic flag_r;

  // Link domain state.
  logic run_l;
  logic master_l;
  logic req_l;
  logic req_seen_r;
  csfp_pkg::csfp_tx_t tx_shadow_r;
  logic [csfp_pkg::CNT_W-1:0] cnt_r;
  logic [csfp_pkg::CNT_W-1:0] fsd_dly_r;
  logic fs_out_r;
  logic fs_oe_r;
  logic fsd_r;
  logic fs_prev_r;
  logic sec_pend_r;
  logic in_sec_r;
  logic [csfp_pkg::WORD_BITS-1:0] tx_sr_r;
  logic dout_r;
  logic dout_oe_r;
  logic [csfp_pkg::BIT_W-1:0] rx_cnt_r;
  logic [csfp_pkg::WORD_BITS-1:0] rx_sr_r;
  csfp_pkg::csfp_rx_t rx_hold_r;
  logic rx_tog_r;

  logic fs_low_nxt;
  logic fsd_low_nxt;
  logic [csfp_pkg::CNT_W-1:0] dly_cnt;
  logic [csfp_pkg::CNT_W-1:0] dly_eff;
  logic fs_now;
  logic fs_fall;
  logic fs_rise;
  logic sec_now;
  logic fs_lvl;

  // ---------------- System domain ----------------

  csfp_sync3 #(.W(1)) u_pd_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(power_down_n),
    .q(pd_q)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      run_r <= 1'b0;
    end else begin
      run_r <= pd_q;
    end
  end

  // Words cross by a toggle handshake; the hold register stays still until acknowledged.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_req_r <= 1'b0;
      tx_hold_r <= csfp_pkg::TX_RST;
    end else if (tx_load && tx_ready) begin
      tx_hold_r <= '{data: tx_data, phone: phone_mode, fsd_delay: fsd_delay};
      tx_req_r <= ~tx_req_r;
    end
  end

  csfp_sync3 #(.W(1)) u_ack_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(req_seen_r),
    .q(ack_q)
  );

  assign tx_ready = (tx_req_r == ack_q);

  csfp_sync3 #(.W(1)) u_rxt_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(rx_tog_r),
    .q(rxt_q)
  );

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rxt_seen_r <= 1'b0;
      rx_data_r <= csfp_pkg::WORD_RST;
      rx_sec_r <= 1'b0;
      rx_valid_r <= 1'b0;
    end else if (rxt_q != rxt_seen_r) begin
      rxt_seen_r <= rxt_q;
      rx_data_r <= rx_hold_r.data;
      rx_sec_r <= rx_hold_r.secondary;
      rx_valid_r <= 1'b1;
    end else begin
      rx_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= phone_mode & ctrl2_flag;
    end
  end

  // ---------------- Link domain ----------------

  csfp_sync3 #(.W(1)) u_run_sync (
    .clk(sclk),
    .rst_n(1'b1),
    .d(run_r),
    .q(run_l)
  );

  csfp_sync3 #(.W(1)) u_ms_sync (
    .clk(sclk),
    .rst_n(run_l),
    .d(master_sel),
    .q(master_l)
  );

  csfp_sync3 #(.W(1)) u_req_sync (
    .clk(sclk),
    .rst_n(run_l),
    .d(tx_req_r),
    .q(req_l)
  );

  // A new word is taken into the shadow whenever a fresh request toggle arrives.
  always_ff @(posedge sclk) begin
    if (!run_l) begin
      req_seen_r <= 1'b0;
      tx_shadow_r <= csfp_pkg::TX_RST;
    end else if (req_l != req_seen_r) begin
      req_seen_r <= req_l;
      tx_shadow_r <= tx_hold_r;
    end
  end

  always_comb begin
    fs_low_nxt = 1'b0;
    if (cnt_r < csfp_pkg::WORD_END) begin
      fs_low_nxt = 1'b1;
    end else if (sec_pend_r && cnt_r >= csfp_pkg::SEC_START && cnt_r < csfp_pkg::SEC_END) begin
      fs_low_nxt = 1'b1;
    end
    dly_eff = (cnt_r == csfp_pkg::CNT_ZERO) ? tx_shadow_r.fsd_delay : fsd_dly_r;
    dly_cnt = cnt_r - dly_eff;
    fsd_low_nxt = (cnt_r >= dly_eff) && (dly_cnt < csfp_pkg::WORD_END);
    fs_now = master_l ? ~fs_low_nxt : frame_sync_n_i;
    fs_fall = fs_prev_r & ~fs_now;
    fs_rise = ~fs_prev_r & fs_now;
    sec_now = fs_fall ? sec_pend_r : in_sec_r;
    fs_lvl = master_l ? fs_out_r : frame_sync_n_i;
  end

  always_ff @(posedge sclk) begin
    if (!run_l) begin
      cnt_r <= csfp_pkg::CNT_ZERO;
    end else if (master_l) begin
      cnt_r <= cnt_r + csfp_pkg::CNT_ONE;
    end else begin
      cnt_r <= csfp_pkg::CNT_ZERO;
    end
  end

  // The delay is frozen for a whole frame, so a new setting never cuts a pulse, though a new delay of zero joins a pulse that ran to the frame end.
  always_ff @(posedge sclk) begin
    if (!run_l) begin
      fsd_dly_r <= csfp_pkg::DELAY_RST;
    end else if (cnt_r == csfp_pkg::CNT_ZERO) begin
      fsd_dly_r <= tx_shadow_r.fsd_delay;
    end
  end

  always_ff @(posedge sclk) begin
    if (!run_l) begin
      fs_out_r <= csfp_pkg::FS_IDLE;
      fsd_r <= csfp_pkg::FS_IDLE;
      fs_oe_r <= 1'b0;
      fs_prev_r <= csfp_pkg::FS_IDLE;
    end else begin
      fs_out_r <= ~(master_l & fs_low_nxt);
      fsd_r <= ~(master_l & fsd_low_nxt);
      fs_oe_r <= master_l;
      fs_prev_r <= fs_now;
    end
  end

  always_ff @(posedge sclk) begin
    if (!run_l) begin
      sec_pend_r <= 1'b0;
      in_sec_r <= 1'b0;
    end else begin
      if (fs_fall) begin
        in_sec_r <= sec_pend_r;
      end
      if (fs_rise) begin
        sec_pend_r <= in_sec_r ? 1'b0 : secondary_request;
      end
    end
  end

  // The whole word is loaded at the falling sync edge, so a shadow update mid-frame leaves the data intact, but its phone bit takes effect at once.
  always_ff @(posedge sclk) begin
    if (!run_l) begin
      tx_sr_r <= csfp_pkg::WORD_RST;
      dout_r <= 1'b0;
      dout_oe_r <= 1'b0;
    end else begin
      dout_oe_r <= ~fs_now;
      if (fs_fall) begin
        tx_sr_r <= {tx_shadow_r.data[csfp_pkg::WORD_BITS-2:0], 1'b0};
        dout_r <= tx_shadow_r.data[csfp_pkg::WORD_BITS-1];
      end else if (!fs_now) begin
        tx_sr_r <= {tx_sr_r[csfp_pkg::WORD_BITS-2:0], 1'b0};
        dout_r <= tx_sr_r[csfp_pkg::WORD_BITS-1];
      end
      if (!fs_now && sec_now && tx_shadow_r.phone) begin
        dout_r <= alternate_data_in;
      end
    end
  end

  always_ff @(negedge sclk) begin
    if (!run_l) begin
      rx_cnt_r <= csfp_pkg::BIT_ZERO;
      rx_sr_r <= csfp_pkg::WORD_RST;
      rx_hold_r <= csfp_pkg::RX_RST;
      rx_tog_r <= 1'b0;
    end else if (!fs_lvl) begin
      rx_sr_r <= {rx_sr_r[csfp_pkg::WORD_BITS-2:0], serial_in};
      if (rx_cnt_r == csfp_pkg::BIT_LAST) begin
        rx_hold_r <= '{data: {rx_sr_r[csfp_pkg::WORD_BITS-2:0], serial_in}, secondary: in_sec_r};
        rx_tog_r <= ~rx_tog_r;
        rx_cnt_r <= csfp_pkg::BIT_ZERO;
      end else begin
        rx_cnt_r <= rx_cnt_r + csfp_pkg::BIT_ONE;
      end
    end else begin
      rx_cnt_r <= csfp_pkg::BIT_ZERO;
    end
  end

  assign frame_sync_n_o = fs_out_r;
  assign frame_sync_n_oe = fs_oe_r;
  assign delayed_frame_sync_n = fsd_r;
  assign serial_out = dout_r;
  assign serial_out_oe = dout_oe_r;
  assign flag = flag_r;
  assign rx_data = rx_data_r;
  assign rx_secondary = rx_sec_r;
  assign rx_valid = rx_valid_r;

endmodule : csfp_frame_port

// File: csfp_dsp_model.sv
// Behavioural signal processor port facing the codec serial link.
`timescale 1ns/100ps
module csfp_dsp_model (
  input wire logic sclk,
  input wire logic drive_fs,
  input wire logic fs_pin,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic [15:0] word,
  output logic fs_n,
  output logic din,
  output logic [15:0] got,
  output int got_cnt
);
  logic [5:0] c = 6'h00;
  logic [15:0] sh = 16'h0000;
  logic [15:0] cap = 16'h0000;
  int n = 0;
  initial fs_n = 1'b1;
  initial got_cnt = 0;
  always @(posedge sclk) begin
    c <= c + 6'h01;
    fs_n <= !(drive_fs && c < 6'h10);
    sh <= fs_pin ? word : {sh[14:0], ~sh[15]};
  end
  assign din = sh[15];
  always @(negedge sclk) begin
    if (dout_oe) begin
      cap = {cap[14:0], dout};
      n++;
      if (n == 16) begin
        got = cap;
        got_cnt++;
        n = 0;
      end
    end else n = 0;
  end
endmodule : csfp_dsp_model

// File: csfp_frame_port_assertions.sv
// Concurrent checks on the link side of the codec serial frame port.
`timescale 1ns/100ps
module csfp_frame_port_assertions (
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic power_down_n,
  input wire logic master_sel,
  input wire logic frame_sync_n_o,
  input wire logic frame_sync_n_oe,
  input wire logic delayed_frame_sync_n,
  input wire logic serial_out_oe,
  input wire logic secondary_request,
  input wire logic [csfp_pkg::CNT_W-1:0] fsd_delay
);
  wire ok = rst_n && power_down_n;
  logic ms_q, fs_q;
  logic [4:0] st_cnt, pd_cnt, fs_lo, fsd_lo;
  logic [7:0] dl_q, since_r, since;
  logic [8:0] dl_cnt;
  // Both slots may have opened a frame, so a delay may be measured from either.
  assign since = (fs_q && !frame_sync_n_o) ? 8'h00 : since_r;
  always_ff @(posedge sclk) begin
    ms_q <= master_sel;
    fs_q <= frame_sync_n_o;
    dl_q <= fsd_delay;
    st_cnt <= (!ok || ms_q != master_sel) ? 5'h00 : st_cnt + {4'h0, st_cnt != 5'h1F};
    pd_cnt <= power_down_n ? 5'h00 : pd_cnt + {4'h0, pd_cnt != 5'h1F};
    dl_cnt <= (dl_q != fsd_delay) ? 9'h000 : dl_cnt + {8'h00, dl_cnt != 9'h1FF};
    since_r <= (since == 8'hFF) ? since : since + 8'h01;
    fs_lo <= frame_sync_n_o ? 5'h00 : fs_lo + {4'h0, fs_lo != 5'h1F};
    fsd_lo <= delayed_frame_sync_n ? 5'h00 : fsd_lo + {4'h0, fsd_lo != 5'h1F};
  end
  default clocking cb @(posedge sclk); endclocking
  default disable iff (!ok);
  property p_out_in_slot;
    frame_sync_n_oe |-> serial_out_oe == !frame_sync_n_o;
  endproperty
  a_out_in_slot: assert property (p_out_in_slot) else $error("data outside slot");
  property p_mode_dir;
    st_cnt == 5'h1F |-> frame_sync_n_oe == master_sel;
  endproperty
  a_mode_dir: assert property (p_mode_dir) else $error("frame pin direction");
  property p_fs_width;
    frame_sync_n_oe |-> fs_lo <= 5'h10 && (!$rose(frame_sync_n_o) || fs_lo == 5'h10);
  endproperty
  a_fs_width: assert property (p_fs_width) else $error("frame width");
  property p_fsd_start;
    $fell(delayed_frame_sync_n) && dl_cnt == 9'h1FF
      |-> since == fsd_delay || since + 8'h80 == fsd_delay;
  endproperty
  a_fsd_start: assert property (p_fsd_start) else $error("delayed frame start");
  property p_fsd_width;
    fsd_lo <= 5'h10 && (!$rose(delayed_frame_sync_n) || fsd_lo == 5'h10);
  endproperty
  a_fsd_width: assert property (p_fsd_width) else $error("delayed frame width");
  property p_quiet;
    !delayed_frame_sync_n && frame_sync_n_o |-> !serial_out_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data during slave frame");
  property p_pd_idle;
    disable iff (!rst_n) pd_cnt == 5'h1F
      |-> !serial_out_oe && !frame_sync_n_oe && delayed_frame_sync_n;
  endproperty
  a_pd_idle: assert property (p_pd_idle) else $error("link active in power down");
  property p_sec_slot;
    $rose(frame_sync_n_o) && frame_sync_n_oe && $past(secondary_request) |-> ##112 $fell(frame_sync_n_o);
  endproperty
  a_sec_slot: assert property (p_sec_slot) else $error("secondary slot missing");
  c_fsd: cover property ($fell(delayed_frame_sync_n));
  c_slave: cover property (st_cnt == 5'h1F && !master_sel);
  c_sec: cover property ($rose(frame_sync_n_o) && $past(secondary_request));
endmodule : csfp_frame_port_assertions
bind csfp_frame_port csfp_frame_port_assertions u_csfp_frame_port_assertions (
  .rst_n(rst_n), .sclk(sclk), .power_down_n(power_down_n), .master_sel(master_sel),
  .frame_sync_n_o(frame_sync_n_o), .frame_sync_n_oe(frame_sync_n_oe),
  .delayed_frame_sync_n(delayed_frame_sync_n), .serial_out_oe(serial_out_oe),
  .secondary_request(secondary_request), .fsd_delay(fsd_delay));

// File: csfp_frame_port_tb_top.sv
// Self-checking bench for the codec serial frame port.
`timescale 1ns/100ps
module csfp_frame_port_tb_top;
  logic clk_sys = 1'b0, sclk = 1'b0, rst_n = 1'b0, power_down_n = 1'b1, master_sel = 1'b1;
  logic drive_fs = 1'b0, sec_req = 1'b0, alt = 1'b0, phone = 1'b0, ctrl2 = 1'b0, tx_load = 1'b0;
  logic [7:0] dly = 8'h00;
  logic [15:0] tx_data = 16'h0000, dsp_word = 16'h0000, w, last_rx, rx_data, got;
  logic fs_o, fs_oe, fsd_n, dout, dout_oe, m_fs, din, flag, tx_ready, rx_valid, rx_sec;
  int got_cnt, error_cnt = 0, n_compared = 0, cyc = 0, n_sec = 0;
  wire fs_pin = fs_oe ? fs_o : m_fs;
  initial forever #50 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #15 sclk = ~sclk;
  end
  csfp_frame_port u_csfp_frame_port (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk),
    .power_down_n(power_down_n), .master_sel(master_sel), .frame_sync_n_i(fs_pin),
    .frame_sync_n_o(fs_o), .frame_sync_n_oe(fs_oe), .delayed_frame_sync_n(fsd_n),
    .serial_in(din), .serial_out(dout), .serial_out_oe(dout_oe), .secondary_request(sec_req),
    .alternate_data_in(alt), .flag(flag), .phone_mode(phone), .ctrl2_flag(ctrl2),
    .fsd_delay(dly), .tx_data(tx_data), .tx_load(tx_load), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_secondary(rx_sec), .rx_valid(rx_valid));
  csfp_dsp_model u_csfp_dsp_model (.sclk(sclk), .drive_fs(drive_fs), .fs_pin(fs_pin),
    .dout(dout), .dout_oe(dout_oe), .word(dsp_word), .fs_n(m_fs), .din(din), .got(got),
    .got_cnt(got_cnt));
  task automatic print_verdict();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [15:0] act, input logic [15:0] exp);
    n_compared++;
    if (act !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask : chk
  task automatic load(input logic [15:0] v, input logic [7:0] d);
    @(negedge clk_sys);
    while (tx_ready !== 1'b1) @(negedge clk_sys);
    tx_data = v;
    dly = d;
    tx_load = 1'b1;
    @(negedge clk_sys);
    tx_load = 1'b0;
  endtask : load
  task automatic frames(input int k);
    int c0;
    c0 = got_cnt;
    while (got_cnt < c0 + k) begin
      @(negedge clk_sys);
      if (rx_valid === 1'b1) last_rx = rx_data;
      if (rx_valid === 1'b1 && rx_sec === 1'b1) n_sec++;
    end
  endtask : frames
  initial begin
    void'($urandom(32'h77d1d23f));
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      w = 16'($urandom);
      dsp_word = 16'($urandom);
      // A delay of zero right after one of 240 would merge two pulses, so it is kept apart.
      load(w, (i == 0) ? 8'h00 : (i == 1) ? 8'hF0 : 8'($urandom_range(240, 1)));
      frames(3);
      chk(got, w);
      chk(last_rx, dsp_word);
    end
    chk(16'(n_sec), 16'h0000);
    w = 16'($urandom);
    load(w, 8'h20);
    sec_req = 1'b1;
    frames(4);
    chk(got, w);
    chk({15'h0000, n_sec > 0}, 16'h0001);
    phone = 1'b1;
    ctrl2 = 1'b1;
    alt = 1'b1;
    load(16'h0000, 8'h10);
    for (int j = 0; j < 8 && got !== 16'hFFFF; j++) frames(1);
    chk(got, 16'hFFFF);
    chk({15'h0000, flag}, 16'h0001);
    phone = 1'b0;
    sec_req = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk({15'h0000, flag}, 16'h0000);
    power_down_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    master_sel = 1'b0;
    drive_fs = 1'b1;
    power_down_n = 1'b1;
    w = 16'($urandom);
    load(w, 8'h00);
    frames(3);
    chk(got, w);
    chk({15'h0000, fs_oe}, 16'h0000);
    print_verdict();
  end
endmodule : csfp_frame_port_tb_top
